// *** slave_fifo_map.svh ***
`ifndef SLAVE_FIFO_MAP_SVH
`define SLAVE_FIFO_MAP_SVH
`define FIFO_COUNT       4
`define FIFO_SEL_W       2
`define DATA_W           8
`define FIFO_DEPTH       64
`define FIFO_PTR_W       6
`define AUTO_LEN_DEF     7'h40
`define PROG_LEVEL_DEF   7'h30
`endif

// *** slave_fifo_master.sv ***
`timescale 1ns/1ps
module slave_fifo_master
  import slave_fifo_pkg::*;
(
  input  wire logic       clk,
  output logic            interface_clock,
  output logic [1:0]      sel,
  output strobe_type      strobeN,
  output logic [7:0]      dataOut
);
  // ------------------------------------------------------------
  // one interface clock frame, 160 ns, clock idle between frames
  // ------------------------------------------------------------
  initial begin
    interface_clock = 1'b0;
    sel = 2'h0;
    strobeN = 5'h1f;
    dataOut = 8'h00;
  end
  task automatic frame(input logic [1:0] s, input logic [4:0] lowN, input logic [7:0] d,
                       input logic drive);
    @(posedge clk);
    #2 sel = s;
    strobeN = lowN;
    // released bus toggles so a stale word is never mistaken for data
    dataOut = drive ? d : ~dataOut;
    repeat (4) @(posedge clk);
    #2 interface_clock = 1'b1;
    repeat (3) @(posedge clk);
    #2 interface_clock = 1'b0;
  endtask
endmodule // slave_fifo_master

// *** slave_fifo_pkg.sv ***
package slave_fifo_pkg;
  typedef struct packed {
    logic chipSelect;
    logic driveEnable;
    logic readStrobe;
    logic writeStrobe;
    logic commitStrobe;
  } strobe_type;
  typedef struct packed {
    logic emptyFlag;
    logic fullFlag;
    logic levelFlag;
  } flags_type;
endpackage

// *** slave_fifo_port.sv ***
// Overview of operation
// - drive enable only steers bus drive, never consumes data
// - drive enable shows prefetched word at the read pointer
// - read needs chip select and read strobe together
// - interface clock rising edge with read strobe advances read pointer
// - data bus driven only while drive enable asserted
// - burst read advances one word per edge while strobe held
// - write needs chip select and write strobe together
// - write stores word, bumps pointer, flags follow the edge
// - burst write captures one word every edge while strobe held
// - commit strobe commits written data as short packet
// - commit on same edge as last write includes that word
// - auto mode commits when byte count reaches auto length
// - selector picks flags and data of one fifo
// - async write captures word on strobe deasserting edge
// - async read increments pointer on strobe asserting edge, bus then shows the next word
`timescale 1ns/1ps
`include "slave_fifo_map.svh"
module slave_fifo_port
  import slave_fifo_pkg::*;
#(
  parameter int DW    = `DATA_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int PW    = `FIFO_PTR_W
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   interfaceClock,
  input  wire logic                   asyncMode,
  input  wire logic                   autoMode,
  input  wire logic [PW:0]            autoCommitLength,
  input  wire logic [PW:0]            progLevel,
  input  wire logic [`FIFO_SEL_W-1:0] fifoSelector,
  input  wire strobe_type             strobeN,
  input  wire logic [DW-1:0]          fifoDataIn,
  output logic      [DW-1:0]          fifoDataOut,
  output logic                        fifoDataOeN,
  output flags_type                   flags,
  output logic                        packetCommitted,
  output logic [PW:0]                 committedLength,
  output logic [`FIFO_SEL_W-1:0]      committedFifo,
  input  wire logic                   hostPop,
  input  wire logic [`FIFO_SEL_W-1:0] hostSel,
  input  wire logic                   hostPush,
  input  wire logic [DW-1:0]          hostData
);
  localparam int NF = `FIFO_COUNT;
  localparam int SW = `FIFO_SEL_W;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // strobe pins are active low; selector and data also cross from the master
  localparam int SYW = 1 + 5 + SW + DW;
  logic [SYW-1:0] syncIn;
  logic [SYW-1:0] syncOut;
  assign syncIn = {interfaceClock, ~strobeN, fifoSelector, fifoDataIn};
  sync_2ff #(.W(SYW)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (syncIn),
    .dout (syncOut)
  );
  logic        ifc;
  strobe_type  stb;
  logic [SW-1:0] sel;
  logic [DW-1:0] din;
  assign ifc = syncOut[SYW-1];
  assign stb = syncOut[SYW-2 -: 5];
  assign sel = syncOut[SW+DW-1 -: SW];
  assign din = syncOut[DW-1:0];

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  logic [DW-1:0] mem_q [NF][DEPTH];
  logic [PW-1:0] rdPtr_q [NF];
  logic [PW-1:0] rdPtr_d [NF];
  logic [PW-1:0] wrPtr_q [NF];
  logic [PW-1:0] wrPtr_d [NF];
  logic [PW:0]   cnt_q [NF];
  logic [PW:0]   cnt_d [NF];
  logic [PW:0]   pend_q [NF];
  logic [PW:0]   pend_d [NF];
  logic          ifcPrev_q, ifcPrev_d;
  logic          wrPrev_q, wrPrev_d;
  logic          rdPrev_q, rdPrev_d;
  logic [DW-1:0] dout_d;
  logic          oeN_d;
  flags_type     flags_d;
  logic          commit_d;
  logic [PW:0]   cLen_d;
  logic [SW-1:0] cFifo_d;
  logic          doWrite, doRead;

  function automatic logic [PW:0] bump(input logic [PW:0] v, input logic up, input logic dn);
    bump = v + {{PW{1'b0}}, up} - {{PW{1'b0}}, dn};
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic rise;
    logic wrFall;
    logic rdRise;
    logic [PW:0] fill;
    rise     = ifc & ~ifcPrev_q;
    wrFall   = wrPrev_q & ~stb.writeStrobe;
    rdRise   = stb.readStrobe & ~rdPrev_q;
    fill     = '0;
    ifcPrev_d = ifc;
    wrPrev_d  = stb.writeStrobe & stb.chipSelect;
    rdPrev_d  = stb.readStrobe & stb.chipSelect;
    rdPtr_d = rdPtr_q;
    wrPtr_d = wrPtr_q;
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    commit_d = 1'b0;
    cLen_d  = committedLength;
    cFifo_d = committedFifo;
    // sync: sample strobes on interface clock edge; async: strobe edges
    doWrite = stb.chipSelect && cnt_q[sel] != DEPTH[PW:0] &&
              (asyncMode ? wrFall : (rise && stb.writeStrobe));
    doRead  = stb.chipSelect && cnt_q[sel] != '0 &&
              (asyncMode ? rdRise : (rise && stb.readStrobe));
    if (doWrite) begin
      wrPtr_d[sel] = wrPtr_q[sel] + 1'b1;
    end
    if (doRead) begin
      rdPtr_d[sel] = rdPtr_q[sel] + 1'b1;
    end
    for (int i = 0; i < NF; i++) begin
      cnt_d[i] = bump(cnt_q[i], doWrite && sel == SW'(i), doRead && sel == SW'(i));
    end
    fill = bump(pend_q[sel], doWrite, 1'b0);
    pend_d[sel] = fill;
    // commit strobe is level sampled; async edges share the same rule
    if (stb.chipSelect && stb.commitStrobe && (asyncMode || rise) && fill != '0) begin
      commit_d = 1'b1;
      cLen_d = fill;
      cFifo_d = sel;
      pend_d[sel] = '0;
    end else if (autoMode && fill >= autoCommitLength && autoCommitLength != '0) begin
      // a strobe on this same edge is absorbed by the full packet, hence the gap
      commit_d = 1'b1;
      cLen_d = fill;
      cFifo_d = sel;
      pend_d[sel] = '0;
    end
    // host side drains the opposite direction into the same storage
    if (hostPush && cnt_q[hostSel] != DEPTH[PW:0] && !(doWrite || doRead)) begin
      wrPtr_d[hostSel] = wrPtr_q[hostSel] + 1'b1;
      cnt_d[hostSel] = bump(cnt_q[hostSel], 1'b1, 1'b0);
    end else if (hostPop && cnt_q[hostSel] != '0 && !(doWrite || doRead)) begin
      rdPtr_d[hostSel] = rdPtr_q[hostSel] + 1'b1;
      cnt_d[hostSel] = bump(cnt_q[hostSel], 1'b0, 1'b1);
    end
    // prefetched word follows pointer and selector, not drive enable
    dout_d = mem_q[sel][rdPtr_d[sel]];
    oeN_d  = ~(stb.chipSelect & stb.driveEnable);
    flags_d.emptyFlag = cnt_d[sel] == '0;
    flags_d.fullFlag  = cnt_d[sel] == DEPTH[PW:0];
    flags_d.levelFlag = cnt_d[sel] >= progLevel;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem_q[sel][wrPtr_q[sel]] <= din;
    end else if (hostPush && cnt_q[hostSel] != DEPTH[PW:0] && !doRead) begin
      mem_q[hostSel][wrPtr_q[hostSel]] <= hostData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < NF; i++) begin
        rdPtr_q[i] <= '0;
        wrPtr_q[i] <= '0;
        cnt_q[i]   <= '0;
        pend_q[i]  <= '0;
      end
      ifcPrev_q       <= 1'b0;
      wrPrev_q        <= 1'b0;
      rdPrev_q        <= 1'b0;
      fifoDataOut     <= '0;
      fifoDataOeN     <= 1'b1;
      flags           <= '{emptyFlag: 1'b1, fullFlag: 1'b0, levelFlag: 1'b0};
      packetCommitted <= 1'b0;
      committedLength <= '0;
      committedFifo   <= '0;
    end else begin
      rdPtr_q         <= rdPtr_d;
      wrPtr_q         <= wrPtr_d;
      cnt_q           <= cnt_d;
      pend_q          <= pend_d;
      ifcPrev_q       <= ifcPrev_d;
      wrPrev_q        <= wrPrev_d;
      rdPrev_q        <= rdPrev_d;
      fifoDataOut     <= dout_d;
      fifoDataOeN     <= oeN_d;
      flags           <= flags_d;
      packetCommitted <= commit_d;
      committedLength <= cLen_d;
      committedFifo   <= cFifo_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  drive_only_oe_a: assert property (@(posedge clk) disable iff (!rstn)
    !fifoDataOeN |-> $past(stb.chipSelect && stb.driveEnable))
    else $error("bus driven without drive enable");
  no_cs_read_a: assert property (@(posedge clk) disable iff (!rstn)
    !stb.chipSelect && !hostPush && !hostPop
    |=> cnt_q[$past(sel)] == $past(cnt_q[sel]))
    else $error("strobe accepted without chip select");
  read_bumps_a: assert property (@(posedge clk) disable iff (!rstn)
    doRead && !asyncMode |=> rdPtr_q[$past(sel)] == $past(rdPtr_q[sel]) + 1'b1)
    else $error("read pointer not advanced");
  write_bumps_a: assert property (@(posedge clk) disable iff (!rstn)
    doWrite |=> cnt_q[$past(sel)] == $past(cnt_q[sel]) + 1'b1 || $past(doRead))
    else $error("write count not advanced");
  empty_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    flags.emptyFlag |-> $past(cnt_d[sel] == '0))
    else $error("empty flag wrong");
  commit_len_a: assert property (@(posedge clk) disable iff (!rstn)
    packetCommitted |-> committedLength != '0)
    else $error("empty packet committed");
  auto_commit_a: assert property (@(posedge clk) disable iff (!rstn)
    autoMode && autoCommitLength != '0 && doWrite && pend_q[sel] == autoCommitLength - 1'b1
    |=> packetCommitted && committedLength == $past(autoCommitLength))
    else $error("auto commit missed");
  full_write_a: assert property (@(posedge clk) disable iff (!rstn)
    cnt_q[sel] == DEPTH[PW:0] && !doRead && !hostPop
    |=> cnt_q[$past(sel)] == DEPTH[PW:0])
    else $error("write into full fifo");
endmodule // slave_fifo_port

// *** slave_fifo_port_tb.sv ***
`timescale 1ns/1ps
module slave_fifo_port_tb;
  import slave_fifo_pkg::*;
  localparam logic [4:0] CS = 5'h10, OE = 5'h08, RD = 5'h04, WR = 5'h02, PE = 5'h01;
  logic        clk, rstn, interface_clock, autoMode, asyncMode, hostPush, oeN, committed;
  logic [7:0]  w0;
  logic [6:0]  autoLen, cLen;
  logic [1:0]  sel, hostSel, cFifo;
  logic [7:0]  dIn, dOut, hostData;
  logic [7:0]  w [4];
  logic [8:0]  expQ [$];
  logic [31:0] lfsrQ;
  strobe_type  sN;
  flags_type   flags;
  int          n_fail, compares, cycles;

  slave_fifo_master m (.clk(clk), .interface_clock(interface_clock), .sel(sel), .strobeN(sN), .dataOut(dIn));
  slave_fifo_port dut (.clk(clk), .rstn(rstn), .interfaceClock(interface_clock), .asyncMode(asyncMode),
    .autoMode(autoMode), .autoCommitLength(autoLen), .progLevel(7'h20), .fifoSelector(sel),
    .strobeN(sN), .fifoDataIn(dIn), .fifoDataOut(dOut), .fifoDataOeN(oeN), .flags(flags),
    .packetCommitted(committed), .committedLength(cLen), .committedFifo(cFifo),
    .hostPop(1'b0), .hostSel(hostSel), .hostPush(hostPush), .hostData(hostData));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic fail(input string msg);
    n_fail++;
    $display("ERROR %0t %s", $time, msg);
  endtask
  task automatic chkBit(input logic g, input logic e, input string msg);
    compares++;
    if (g !== e) fail(msg);
  endtask
  task automatic chkWord(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) fail("read word mismatch");
  endtask
  task automatic chkCommit(input logic [8:0] e);
    compares++;
    if ({cFifo, cLen} !== e) fail("commit fifo or length mismatch");
  endtask
  task automatic note(input logic [1:0] f, input logic [6:0] n);
    expQ.push_back({f, n});
  endtask
  // sync path needs about six clk before results are settled
  task automatic settle;
    repeat (6) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [1:0] s, input logic [4:0] on);
    lfsrQ = lfsr(lfsrQ);
    m.frame(s, ~on, lfsrQ[7:0], 1'b1);
  endtask
  task automatic rd(input logic [1:0] s, input logic [4:0] on);
    m.frame(s, ~on, 8'h00, 1'b0);
    settle();
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------
  // commit monitor and hang guard
  // ------------------------------------------------------------
  // negedge keeps the pulse away from the edge that launches it
  always @(negedge clk) begin
    if (committed === 1'b1) begin
      if (expQ.size() == 0) fail("unexpected commit");
      else chkCommit(expQ.pop_front());
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    autoMode = 1'b0;
    asyncMode = 1'b0;
    autoLen = 7'h00;
    hostPush = 1'b0;
    hostSel = 2'h0;
    hostData = 8'h00;
    lfsrQ = 32'hc0eb6fe2;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    settle();
    chkBit(oeN, 1'b1, "bus driven after reset");
    chkBit(flags.emptyFlag, 1'b1, "not empty after reset");
    wr(2'h0, WR | PE);
    settle();
    chkBit(flags.emptyFlag, 1'b1, "write taken without select");
    note(2'h0, 7'h04);
    wr(2'h0, CS | WR);
    w0 = lfsrQ[7:0];
    settle();
    chkBit(flags.emptyFlag, 1'b0, "single write not stored");
    rd(2'h0, PE);
    wr(2'h0, CS | WR);
    wr(2'h0, CS | WR);
    wr(2'h0, CS | WR | PE);
    rd(2'h0, CS);
    note(2'h2, 7'h01);
    wr(2'h2, CS | WR);
    rd(2'h2, CS);
    rd(2'h2, CS | PE);
    rd(2'h2, CS);
    autoMode = 1'b1;
    autoLen = 7'h03;
    note(2'h3, 7'h03);
    note(2'h3, 7'h01);
    for (int i = 0; i < 3; i++) wr(2'h3, CS | WR);
    rd(2'h3, CS);
    wr(2'h3, CS | WR);
    rd(2'h3, CS | PE);
    rd(2'h3, CS);
    autoMode = 1'b0;
    for (int i = 0; i < 4; i++) begin
      lfsrQ = lfsr(lfsrQ);
      w[i] = lfsrQ[7:0];
      @(posedge clk);
      #2 hostPush = 1'b1;
      hostSel = 2'h1;
      hostData = w[i];
    end
    @(posedge clk);
    #2 hostPush = 1'b0;
    rd(2'h1, CS);
    chkBit(oeN, 1'b1, "bus driven without enable");
    chkBit(flags.levelFlag, 1'b0, "level flag set early");
    rd(2'h1, CS | OE);
    chkBit(oeN, 1'b0, "bus not driven with enable");
    chkWord(dOut, w[0]);
    rd(2'h1, CS | OE);
    chkWord(dOut, w[0]);
    rd(2'h1, CS | OE | RD);
    chkWord(dOut, w[1]);
    rd(2'h1, CS | OE | RD);
    chkWord(dOut, w[2]);
    rd(2'h1, OE | RD);
    chkWord(dOut, w[2]);
    rd(2'h1, 5'h00);
    chkBit(oeN, 1'b1, "bus still driven after release");
    // strobe edges act on their own; the interface clock is ignored
    asyncMode = 1'b1;
    note(2'h2, 7'h01);
    wr(2'h2, CS | WR);
    rd(2'h2, CS);
    rd(2'h2, CS | PE);
    rd(2'h2, CS | OE | RD);
    rd(2'h2, CS | OE);
    rd(2'h2, CS | OE | RD);
    chkBit(flags.emptyFlag, 1'b1, "async reads did not drain");
    rd(2'h2, 5'h00);
    asyncMode = 1'b0;
    hostPush = 1'b1;
    repeat (70) @(posedge clk);
    #2 hostPush = 1'b0;
    wr(2'h1, CS | WR);
    settle();
    chkBit(flags.fullFlag, 1'b1, "full flag missing");
    chkBit(flags.levelFlag, 1'b1, "level flag missing");
    rd(2'h0, CS | OE);
    chkWord(dOut, w0);
    if (expQ.size() != 0) fail("missing commit");
    report_and_stop();
  end
endmodule // slave_fifo_port_tb

// *** sync_2ff.sv ***
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_d;
  always_comb begin
    meta_d = din;
    out_d  = meta_q;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= meta_d;
      dout   <= out_d;
    end
  end
endmodule // sync_2ff
